/* hdl/tqws_regs.vh */
// How it works
// - each entry serves its count of messages back to back from its queue before moving on.
// - entries are visited in ascending index order, entry n then entry n+1.
// - after entry 15 the scheduler wraps to entry 0.
// - each entry holds a 4-bit software-written queue selector naming any of 16 queues.
// - each 32-bit entry register holds four entries, selector in the low nibble, count above it.
// - entries 0 to 3 sit in a first register of the same layout, entry 3 leads to entry 4.
`ifndef TQWS_REGS_VH
`define TQWS_REGS_VH
`define TQWS_OFF_ENT_0_3   12'h000
`define TQWS_OFF_ENT_4_7   12'h004
`define TQWS_OFF_ENT_8_11  12'h008
`define TQWS_OFF_ENT_12_15 12'h00C
`define TQWS_OFF_STATUS    12'h010
`define TQWS_SEL_LSB       0
`define TQWS_CNT_LSB       4
`define TQWS_FIELD_W       4
`define TQWS_ENTRY_W       8
`define TQWS_NUM_ENTRIES   16
`define TQWS_CNT_RESET     4'h0
`endif

/* hdl/tqws_scheduler.v */
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "tqws_regs.vh"

module tqws_scheduler #(
  parameter NUM_ENT = `TQWS_NUM_ENTRIES, // schedule entries
  parameter FLD_W   = `TQWS_FIELD_W,     // selector and count width
  parameter ENT_W   = `TQWS_ENTRY_W      // bits per entry
) (
  input  wire        core_clk_i,      // peripheral clock
  input  wire        rst_i,           // sync reset, high
  input  wire        psel_i,          // apb select
  input  wire        penable_i,       // apb enable
  input  wire        pwrite_i,        // apb direction
  input  wire [11:0] paddr_i,         // apb byte address
  input  wire [31:0] pwdata_i,        // apb write data
  output wire        pready_o,        // apb ready
  output wire [31:0] prdata_o,        // apb read data
  output wire        pslverr_o,       // apb error
  output wire        msg_req_o,       // request one message
  output wire [3:0]  msg_queue_o,     // queue to serve
  input  wire        msg_done_i       // message sent
);

  // the pointer wraps for free only while NUM_ENT equals 2**FLD_W
  localparam        REG_ENT  = 4;
  localparam        NUM_REG  = NUM_ENT / REG_ENT;
  localparam        MAP_W    = NUM_ENT * ENT_W;
  localparam        STAT_PAD = 32 - 2 * FLD_W;
  localparam [31:0] RD_ZERO  = 32'h0000_0000;

  // apb decode
  wire                     acc;
  wire                     setup;
  wire                     wr_acc;
  wire                     hit_0_3;
  wire                     hit_4_7;
  wire                     hit_8_11;
  wire                     hit_12_15;
  wire                     hit_stat;
  wire                     mapped;
  wire [NUM_REG-1:0]       reg_hit;

  // schedule map, one byte per entry
  reg  [MAP_W-1:0]         map_q;
  wire [MAP_W-1:0]         map_d;
  wire [MAP_W-1:0]         map_rst;

  // current entry
  reg  [FLD_W-1:0]         entry_q;
  reg  [FLD_W-1:0]         entry_d;
  reg  [FLD_W-1:0]         served_q;
  reg  [FLD_W-1:0]         served_d;
  reg  [FLD_W-1:0]         queue_q;
  reg  [FLD_W-1:0]         queue_d;
  reg  [FLD_W-1:0]         cur_cnt;
  wire [FLD_W-1:0]         served_inc;
  wire [FLD_W-1:0]         entry_inc;
  wire                     cnt_zero;
  wire                     last_msg;
  wire                     adv;

  // per-entry terms of the and-or selection
  wire [NUM_ENT*FLD_W-1:0] cnt_terms;
  wire [NUM_ENT*FLD_W-1:0] sel_terms;
  integer                  i;
  integer                  j;

  // read path
  reg  [31:0]              rdata_q;
  reg  [31:0]              rdata_d;

  // only the five word offsets answer without error
  assign acc       = psel_i & penable_i;
  assign setup     = psel_i & ~penable_i;
  assign wr_acc    = acc & pwrite_i;
  assign hit_0_3   = (paddr_i == `TQWS_OFF_ENT_0_3);
  assign hit_4_7   = (paddr_i == `TQWS_OFF_ENT_4_7);
  assign hit_8_11  = (paddr_i == `TQWS_OFF_ENT_8_11);
  assign hit_12_15 = (paddr_i == `TQWS_OFF_ENT_12_15);
  assign hit_stat  = (paddr_i == `TQWS_OFF_STATUS);
  assign mapped    = hit_0_3 | hit_4_7 | hit_8_11 | hit_12_15 | hit_stat;
  assign reg_hit   = {hit_12_15, hit_8_11, hit_4_7, hit_0_3};

  genvar g;
  generate
    for (g = 0; g < NUM_ENT; g = g + 1) begin : g_ent
      localparam [FLD_W-1:0] IDX = g;
      wire                   ent_wr;
      wire [FLD_W-1:0]       sel_new;
      wire [FLD_W-1:0]       cnt_new;
      wire [FLD_W-1:0]       sel_nxt;
      wire [FLD_W-1:0]       cnt_nxt;

      assign ent_wr  = wr_acc & reg_hit[g / REG_ENT];
      assign sel_new = pwdata_i[(g % REG_ENT) * ENT_W + `TQWS_SEL_LSB +: FLD_W];
      assign cnt_new = pwdata_i[(g % REG_ENT) * ENT_W + `TQWS_CNT_LSB +: FLD_W];

      assign sel_nxt = ent_wr ? sel_new : map_q[g*ENT_W + `TQWS_SEL_LSB +: FLD_W];
      assign cnt_nxt = ent_wr ? cnt_new : map_q[g*ENT_W + `TQWS_CNT_LSB +: FLD_W];
      assign map_d[g*ENT_W + `TQWS_SEL_LSB +: FLD_W]   = sel_nxt;
      assign map_d[g*ENT_W + `TQWS_CNT_LSB +: FLD_W]   = cnt_nxt;
      assign map_rst[g*ENT_W + `TQWS_SEL_LSB +: FLD_W] = IDX;
      assign map_rst[g*ENT_W + `TQWS_CNT_LSB +: FLD_W] = `TQWS_CNT_RESET;

      // count of the entry in service now, selector of the one served next
      assign cnt_terms[g*FLD_W +: FLD_W] = (entry_q == IDX) ?
        map_q[g*ENT_W + `TQWS_CNT_LSB +: FLD_W] : {FLD_W{1'b0}};
      assign sel_terms[g*FLD_W +: FLD_W] = (entry_d == IDX) ?
        sel_nxt : {FLD_W{1'b0}};
    end
  endgenerate

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      map_q <= map_rst;
    end else begin
      map_q <= map_d;
    end
  end

  // and-or select keeps the count path free of a wide shifter
  always @* begin
    cur_cnt = {FLD_W{1'b0}};
    for (i = 0; i < NUM_ENT; i = i + 1) begin
      cur_cnt = cur_cnt | cnt_terms[i*FLD_W +: FLD_W];
    end
  end

  assign cnt_zero   = (cur_cnt == `TQWS_CNT_RESET);
  assign served_inc = served_q + {{(FLD_W-1){1'b0}}, 1'b1};
  assign entry_inc  = entry_q + {{(FLD_W-1){1'b0}}, 1'b1};
  assign last_msg   = msg_done_i & (served_inc == cur_cnt);
  assign adv        = cnt_zero | last_msg;

  // a zero count passes the entry in one idle cycle
  always @* begin
    entry_d  = entry_q;
    served_d = served_q;
    if (adv) begin
      entry_d  = entry_inc;                // 15 wraps to 0
      served_d = {FLD_W{1'b0}};
    end else if (msg_done_i) begin
      served_d = served_inc;
    end
  end

  always @* begin
    queue_d = {FLD_W{1'b0}};
    for (j = 0; j < NUM_ENT; j = j + 1) begin
      queue_d = queue_d | sel_terms[j*FLD_W +: FLD_W];
    end
  end

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      entry_q <= {FLD_W{1'b0}};
    end else begin
      entry_q <= entry_d;
    end
  end

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      served_q <= {FLD_W{1'b0}};
    end else begin
      served_q <= served_d;
    end
  end

  // taken from next-state values so the queue never lags the pointer
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      queue_q <= {FLD_W{1'b0}};
    end else begin
      queue_q <= queue_d;
    end
  end

  // unmapped offsets read as zero
  always @* begin
    rdata_d = RD_ZERO;
    if (hit_0_3) begin
      rdata_d = map_q[0 +: 32];
    end else if (hit_4_7) begin
      rdata_d = map_q[32 +: 32];
    end else if (hit_8_11) begin
      rdata_d = map_q[64 +: 32];
    end else if (hit_12_15) begin
      rdata_d = map_q[96 +: 32];
    end else if (hit_stat) begin
      rdata_d = {{STAT_PAD{1'b0}}, served_q, entry_q};
    end
  end

  // captured at setup so prdata stands through the access phase
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      rdata_q <= RD_ZERO;
    end else if (setup) begin
      rdata_q <= rdata_d;
    end
  end

  assign pready_o    = 1'b1;
  assign pslverr_o   = acc & ~mapped;
  assign prdata_o    = rdata_q;
  assign msg_req_o   = ~cnt_zero;
  assign msg_queue_o = queue_q;

endmodule // tqws_scheduler
`default_nettype wire

/* tb/tqws_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module tqws_properties (
  input wire logic        core_clk_i,  // peripheral clock
  input wire logic        rst_i,       // sync reset, high
  input wire logic        psel_i,      // apb select
  input wire logic        penable_i,   // apb enable
  input wire logic [11:0] paddr_i,     // apb byte address
  input wire logic        pready_o,    // apb ready
  input wire logic        pslverr_o,   // apb error
  input wire logic        msg_req_o,   // request one message
  input wire logic        msg_done_i,  // message sent
  input wire logic [3:0]  msg_queue_o  // queue to serve
);
  property p_hold; @(posedge core_clk_i) disable iff(rst_i)
    msg_req_o&&!msg_done_i&&!psel_i |=> msg_req_o&&$stable(msg_queue_o); endproperty
  a_hold: assert property(p_hold) else $error("entry left early");
  property p_ready; @(posedge core_clk_i) disable iff(rst_i)
    psel_i&&penable_i |-> pready_o; endproperty
  a_ready: assert property(p_ready) else $error("ready low in access");
  property p_slverr; @(posedge core_clk_i) disable iff(rst_i)
    psel_i&&penable_i&&paddr_i>12'h010 |-> pslverr_o; endproperty
  a_slverr: assert property(p_slverr) else $error("no error on unmapped");
  property p_noerr; @(posedge core_clk_i) disable iff(rst_i)
    psel_i&&penable_i&&paddr_i<=12'h010&&paddr_i[1:0]==2'h0 |-> !pslverr_o; endproperty
  a_noerr: assert property(p_noerr) else $error("error on mapped word");
  property p_rst_idle; @(posedge core_clk_i)
    rst_i |=> !msg_req_o; endproperty
  a_rst_idle: assert property(p_rst_idle) else $error("request after reset");
  property p_rst_queue; @(posedge core_clk_i)
    rst_i |=> msg_queue_o==4'h0; endproperty
  a_rst_queue: assert property(p_rst_queue) else $error("queue not 0 after reset");
  property p_first_step; @(posedge core_clk_i)
    rst_i ##1 !rst_i |=> msg_queue_o==4'h1; endproperty
  a_first_step: assert property(p_first_step) else $error("no step to entry 1");
endmodule // tqws_properties
bind tqws_scheduler tqws_properties u_prop(.*);
`default_nettype wire

/* tb/tqws_engine.sv */
`timescale 1ns/1ns
`default_nettype none
module tqws_engine(input wire logic clk_i,en_i,req_i,output logic done_o);
  initial done_o=0;
  // random gaps mimic a slow fetch
  always @(posedge clk_i) done_o<=en_i&&req_i&&!done_o&&$urandom%3==0;
endmodule // tqws_engine
`default_nettype wire

/* tb/test_tqws_scheduler.sv */
`timescale 1ns/1ns
`default_nettype none
module test_tqws_scheduler;
  logic c=0,rs=1,s=0,en=0,w=0,g=0,y,x,e,q,d;
  logic [11:0] a=0;
  logic [31:0] wd=0,rd,r,f[4];
  logic [3:0] u,m[$];
  int err_count=0,comparisons=0,n=0,t;
  always #5 c=~c;
  tqws_scheduler dut_u(.core_clk_i(c),.rst_i(rs),.psel_i(s),.penable_i(en),.pwrite_i(w),
    .paddr_i(a),.pwdata_i(wd),.pready_o(y),.prdata_o(rd),.pslverr_o(x),.msg_req_o(q),
    .msg_queue_o(u),.msg_done_i(d));
  tqws_engine eng_u(.clk_i(c),.en_i(g),.req_i(q),.done_o(d));
  task ck(logic [31:0] v,z);
    comparisons++;
    if(v!==z) begin err_count++; $display("Error %0t %h %h",$time,v,z); end
  endtask
  task ax(logic o,logic [11:0] p,logic [31:0] v);
    s<=1; w<=o; a<=p; wd<=v; @(posedge c) en<=1; t=0;
    do @(posedge c); while(y!==1&&++t<9);
    r=rd; e=x; ck(y,1); s<=0; en<=0; @(posedge c);
  endtask
  task wrap_up;
    $display("errors %0d of %0d",err_count,comparisons);
    if(err_count==0&&comparisons>0) $display("[ PASS ]"); else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge c) if(g&&q&&d) begin
    if(m.size()==0) for(int k=0;k<16;k++)
      repeat(f[k/4][k%4*8+4+:4]) m.push_back(f[k/4][k%4*8+:4]);
    ck(u,m.pop_front());
    n++;
  end
  initial begin
    void'($urandom(16));
    repeat(12) @(posedge c); rs<=0;
    ax(0,0,0);
    ck(r,32'h03020100);
    // park the pointer on entry 0 before the full table goes in
    ax(1,0,32'h10); repeat(20) @(posedge c);
    ax(0,12'h10,0);
    ck(r,32'h0);
    for(int i=0;i<4;i++) begin
      f[i]=$urandom|(i?0:16); ax(1,12'(4*i),f[i]); ax(0,12'(4*i),0);
      ck(r,f[i]);
    end
    ax(1,12'h14,0); ck(e,1);
    g<=1; for(t=0;t<5000&&n<50;t++) @(posedge c);
    ck(n>=50,1);
    wrap_up;
  end
endmodule // test_tqws_scheduler
`default_nettype wire
